// [inc/mcz_pkg.sv]
package mcz_pkg;
   localparam int SYS_CLK_HZ = 200_000_000;
   localparam int LPF_CLK_HZ = 256_000;
   localparam int LPF_TICK_CYC = SYS_CLK_HZ / LPF_CLK_HZ;
   localparam int LPF_SHIFT = 9;
   localparam int HPF_SHIFT = 10;
   localparam int INT_IN_SHIFT = 8;

   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_COEF = 8'h01;
   localparam logic [7:0] ADDR_GAIN_A = 8'h02;
   localparam logic [7:0] ADDR_BYPASS = 8'h05;
   localparam logic [7:0] ADDR_SAMPLE_A = 8'h06;
   localparam logic [7:0] ADDR_FIRST_STATUS_WORD = 8'h09;
   localparam logic [7:0] ADDR_FIRST_MASK_WORD = 8'h0a;
   localparam logic [7:0] ADDR_SECOND_STATUS_WORD = 8'h0b;
   localparam logic [7:0] ADDR_SECOND_MASK_WORD = 8'h0c;

   localparam int CFG_INTEG_BIT = 0;
   localparam int CFG_ROUTE_LSB = 8;
   localparam int ST0_READY_BIT = 17;
   localparam int ST1_ZX_LSB = 9;

   localparam logic [15:0] CONFIG_RST = 16'h0000;
   localparam logic [23:0] COEF_RST = 24'h000000;
   localparam logic [23:0] GAIN_RST = 24'h000000;
   localparam logic [23:0] BYPASS_RST = 24'h000000;

   localparam logic [23:0] FS_POS = 24'h5a7540;
   localparam logic [23:0] FS_NEG = 24'ha58ac0;
   localparam logic [23:0] ZX_VOLT_THR = FS_POS / 24'h00000a;
   localparam logic signed [24:0] GAIN_ONE = 25'sh0800000;
   localparam logic signed [49:0] SAT_HI = 50'sh00000007fffff;
   localparam logic signed [49:0] SAT_LO = -50'sh0000000800000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } mcz_reg_req_t;
endpackage : mcz_pkg

// [hw/mcz_channel_path.sv]
`timescale 1ns/1ps
module mcz_channel_path
   import mcz_pkg::*;
#(
   parameter int TICK_CYC = LPF_TICK_CYC
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Converter frame strobe and samples
   input wire logic i_adc_valid,
   input wire logic [2:0][23:0] i_adc_volt,
   input wire logic [3:0][23:0] i_adc_curr,
   // Register port
   input wire mcz_reg_req_t i_reg,
   output logic [31:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // Computational paths
   output logic o_path_valid,
   output logic [2:0][23:0] o_path_volt,
   output logic [2:0][23:0] o_path_curr,
   output logic [2:0][23:0] o_path_power,
   // Interrupt pins
   output logic o_sample_interrupt_n,
   output logic o_event_interrupt_n
);

   function automatic logic [23:0] sat24(input logic signed [49:0] x);
      if (x > SAT_HI)
         return 24'h7fffff;
      else if (x < SAT_LO)
         return 24'h800000;
      return x[23:0];
   endfunction : sat24
   function automatic int route_dst(input logic [1:0] code, input int src);
      unique case (code)
         2'b01: return (src + 1) % 3;
         2'b10: return (src + 2) % 3;
         default: return src;
      endcase
   endfunction : route_dst
   function automatic logic [31:0] ext28(input logic [23:0] v);
      return {4'h0, {4{v[23]}}, v};
   endfunction : ext28
   logic [15:0] config_q;
   logic [23:0] coef_q;
   logic [2:0][23:0] gain_q;
   logic [23:0] bypass_q;
   logic ready_q;
   logic first_mask_word_q;
   logic [5:0] st1_q;
   logic [5:0] second_mask_word_q;
   logic s1_valid_q;
   logic s2_valid_q;
   logic [6:0][23:0] pre_q;
   logic [6:0][23:0] hf_q;
   logic [2:0][23:0] samp_q;
   logic [3:0][23:0] integ_q;
   logic [5:0] zx_ev_q;
   logic tick_q;
   localparam logic [$clog2(TICK_CYC)-1:0] TICK_LAST = ($clog2(TICK_CYC))'(TICK_CYC - 1);
   logic [$clog2(TICK_CYC)-1:0] tick_cnt_q;
   logic integ_on;
   logic [2:0][23:0] route_v;

   assign integ_on = config_q[CFG_INTEG_BIT];
   // Register writes
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         config_q <= CONFIG_RST;
         coef_q <= COEF_RST;
         gain_q <= {3{GAIN_RST}};
         bypass_q <= BYPASS_RST;
         first_mask_word_q <= 1'b0;
         second_mask_word_q <= 6'h00;
      end
      else if (i_reg.wr)
      begin
         if (i_reg.addr == ADDR_CONFIG)
            config_q <= i_reg.wdata[15:0];
         if (i_reg.addr == ADDR_COEF)
            coef_q <= i_reg.wdata[23:0];
         for (int k = 0; k < 3; k++)
            if (i_reg.addr == ADDR_GAIN_A + 8'(k))
               gain_q[k] <= i_reg.wdata[23:0];
         if (i_reg.addr == ADDR_BYPASS)
            bypass_q <= i_reg.wdata[23:0];
         if (i_reg.addr == ADDR_FIRST_MASK_WORD)
            first_mask_word_q <= i_reg.wdata[ST0_READY_BIT];
         if (i_reg.addr == ADDR_SECOND_MASK_WORD)
            second_mask_word_q <= i_reg.wdata[ST1_ZX_LSB +: 6];
      end
   end

   // Register reads answer one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_reg_rdata <= 32'h00000000;
         o_reg_rvalid <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= i_reg.rd;
         o_reg_rdata <= 32'h00000000;
         if (i_reg.rd)
         begin
            unique case (i_reg.addr)
               ADDR_CONFIG: o_reg_rdata <= {16'h0000, config_q};
               ADDR_COEF: o_reg_rdata <= ext28(coef_q);
               ADDR_GAIN_A: o_reg_rdata <= ext28(gain_q[0]);
               ADDR_GAIN_A + 8'h01: o_reg_rdata <= ext28(gain_q[1]);
               ADDR_GAIN_A + 8'h02: o_reg_rdata <= ext28(gain_q[2]);
               ADDR_BYPASS: o_reg_rdata <= {8'h00, bypass_q};
               ADDR_SAMPLE_A: o_reg_rdata <= {{8{samp_q[0][23]}}, samp_q[0]};
               ADDR_SAMPLE_A + 8'h01: o_reg_rdata <= {{8{samp_q[1][23]}}, samp_q[1]};
               ADDR_SAMPLE_A + 8'h02: o_reg_rdata <= {{8{samp_q[2][23]}}, samp_q[2]};
               ADDR_FIRST_STATUS_WORD: o_reg_rdata <= 32'(ready_q) << ST0_READY_BIT;
               ADDR_FIRST_MASK_WORD: o_reg_rdata <= 32'(first_mask_word_q) << ST0_READY_BIT;
               ADDR_SECOND_STATUS_WORD: o_reg_rdata <= 32'(st1_q) << ST1_ZX_LSB;
               ADDR_SECOND_MASK_WORD: o_reg_rdata <= 32'(second_mask_word_q) << ST1_ZX_LSB;
               default: o_reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Pipeline strobes: gain/integrator, then filter, then capture and routing
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         s1_valid_q <= 1'b0;
         s2_valid_q <= 1'b0;
         o_path_valid <= 1'b0;
      end
      else
      begin
         s1_valid_q <= i_adc_valid;
         s2_valid_q <= s1_valid_q;
         o_path_valid <= s2_valid_q;
      end
   end

   genvar gk;
   generate
      for (gk = 0; gk < 3; gk++)
      begin : g_volt
         logic signed [24:0] fac;
         logic signed [49:0] prod;
         assign fac = GAIN_ONE + 25'($signed(gain_q[gk]));
         assign prod = 50'($signed(i_adc_volt[gk]) * fac);
         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst)
               pre_q[gk] <= 24'h000000;
            else if (i_adc_valid)
               pre_q[gk] <= sat24(prod >>> 23);
         end
      end

      for (gk = 0; gk < 4; gk++)
      begin : g_integ
         logic signed [24:0] leak;
         logic signed [49:0] acc;
         assign leak = GAIN_ONE + 25'($signed(coef_q));
         assign acc = 50'(($signed(integ_q[gk]) * leak) >>> 23)
            + 50'($signed(i_adc_curr[gk]) >>> INT_IN_SHIFT);
         // The state is flushed while off so enabling starts from rest
         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst || !integ_on)
               integ_q[gk] <= 24'h000000;
            else if (i_adc_valid)
               integ_q[gk] <= sat24(acc);
         end
         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst)
               pre_q[3+gk] <= 24'h000000;
            else if (i_adc_valid)
               pre_q[3+gk] <= integ_on ? sat24(acc) : i_adc_curr[gk];
         end
      end

      for (gk = 0; gk < 7; gk++)
      begin : g_hpf
         logic [23:0] xp_q;
         logic [23:0] yp_q;
         logic signed [49:0] y;
         assign y = 50'($signed(pre_q[gk])) - 50'($signed(xp_q)) + 50'($signed(yp_q))
            - 50'($signed(yp_q) >>> HPF_SHIFT);
         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst)
            begin
               xp_q <= 24'h000000;
               yp_q <= 24'h000000;
               hf_q[gk] <= 24'h000000;
            end
            else if (s1_valid_q)
            begin
               xp_q <= pre_q[gk];
               yp_q <= sat24(y);
               hf_q[gk] <= (bypass_q != 24'h000000) ? pre_q[gk] : sat24(y);
            end
         end
      end
   endgenerate

   // A path that no source routes to carries zero; on a clash the lower phase wins
   always_comb
   begin
      route_v = '0;
      for (int d = 0; d < 3; d++)
         for (int s = 2; s >= 0; s--)
            if (route_dst(config_q[CFG_ROUTE_LSB + 2*s +: 2], s) == d)
               route_v[d] = hf_q[s];
   end
   generate
      for (gk = 0; gk < 3; gk++)
      begin : g_path
         logic signed [49:0] pw;
         assign pw = 50'($signed(route_v[gk]) * $signed(hf_q[3+gk]));
         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst)
            begin
               samp_q[gk] <= 24'h000000;
               o_path_volt[gk] <= 24'h000000;
               o_path_curr[gk] <= 24'h000000;
               o_path_power[gk] <= 24'h000000;
            end
            else if (s2_valid_q)
            begin
               samp_q[gk] <= hf_q[gk];
               o_path_volt[gk] <= route_v[gk];
               o_path_curr[gk] <= hf_q[3+gk];
               o_path_power[gk] <= sat24(pw >>> 23);
            end
         end
      end
   endgenerate

   // 256 kHz tick for the crossing low-pass
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (tick_cnt_q == TICK_LAST);
         tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
      end
   end
   generate
      for (gk = 0; gk < 6; gk++)
      begin : g_zx
         logic [23:0] lp_q;
         logic [23:0] peak_q;
         logic sgn_q;
         logic signed [25:0] diff;
         logic [23:0] lp_d;
         logic [23:0] mag;
         logic big;
         assign diff = 26'($signed(hf_q[gk])) - 26'($signed(lp_q));
         assign lp_d = lp_q + 24'(diff >>> LPF_SHIFT);
         assign mag = lp_d[23] ? 24'(-lp_d) : lp_d;
         // Current detectors ignore amplitude; voltage needs a real half-cycle
         assign big = (gk >= 3) || (peak_q >= ZX_VOLT_THR);
         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst)
            begin
               lp_q <= 24'h000000;
               peak_q <= 24'h000000;
               sgn_q <= 1'b0;
               zx_ev_q[gk] <= 1'b0;
            end
            else
            begin
               zx_ev_q[gk] <= 1'b0;
               if (tick_q)
               begin
                  lp_q <= lp_d;
                  sgn_q <= lp_d[23];
                  if (lp_d[23] != sgn_q)
                  begin
                     zx_ev_q[gk] <= big;
                     peak_q <= 24'h000000;
                  end
                  else if (mag > peak_q)
                     peak_q <= mag;
               end
            end
         end
      end
   endgenerate
   // Status flags: a new event outweighs a same-cycle write-one clear
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         ready_q <= 1'b0;
         st1_q <= 6'h00;
      end
      else
      begin
         ready_q <= (ready_q & ~(i_reg.wr && i_reg.addr == ADDR_FIRST_STATUS_WORD
            && i_reg.wdata[ST0_READY_BIT])) | s2_valid_q;
         st1_q <= (st1_q & ~({6{i_reg.wr && i_reg.addr == ADDR_SECOND_STATUS_WORD}}
            & i_reg.wdata[ST1_ZX_LSB +: 6])) | zx_ev_q;
      end
   end
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_sample_interrupt_n <= 1'b1;
         o_event_interrupt_n <= 1'b1;
      end
      else
      begin
         o_sample_interrupt_n <= ~(ready_q & first_mask_word_q);
         o_event_interrupt_n <= ~|(st1_q & second_mask_word_q);
      end
   end

   a_integ_bypass: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_adc_valid && !integ_on |=> pre_q[3] == $past(i_adc_curr[0]))
      else $error("current path altered while integrator off");
   a_coef_reset: assert property (@(posedge i_clk)
      i_sys_rst |=> coef_q == COEF_RST && !integ_on)
      else $error("coefficient or integrator enable not cleared by reset");
   a_gain_unity: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_adc_valid && gain_q[1] == 24'h000000 |=> pre_q[1] == $past(i_adc_volt[1]))
      else $error("zero gain does not pass voltage unchanged");
   a_hpf_bypass: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s1_valid_q && bypass_q != 24'h000000 |=> hf_q[2] == $past(pre_q[2]))
      else $error("filter not bypassed");
   a_sample_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s1_valid_q |=> ##1 samp_q[0] == $past(hf_q[0]))
      else $error("sample register not loaded from filter output");
   a_ready_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_adc_valid |-> ##3 ready_q ##1 (o_sample_interrupt_n == !first_mask_word_q))
      else $error("data ready flag or its interrupt wrong");
   a_route_default: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s2_valid_q && config_q[13:8] == 6'h3f |=> o_path_volt[1] == $past(hf_q[1]))
      else $error("route code 11 does not act as 00");
   a_read_sext: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_reg.rd && i_reg.addr == ADDR_SAMPLE_A |=>
      o_reg_rvalid && o_reg_rdata[31:24] == {8{o_reg_rdata[23]}})
      else $error("sample read not sign extended");
   a_zx_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      zx_ev_q[4] |=> st1_q[4] ##1 (!second_mask_word_q[4] || !o_event_interrupt_n))
      else $error("current crossing flag not set");
   a_irq_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (st1_q & second_mask_word_q) == 6'h00 |=> o_event_interrupt_n)
      else $error("event interrupt low with no masked flag");

endmodule : mcz_channel_path

// [bench/mcz_host_model.sv]
`timescale 1ns/1ps
module mcz_host_model
   import mcz_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Register port
   output mcz_reg_req_t o_reg,
   input wire logic [31:0] i_reg_rdata,
   input wire logic i_reg_rvalid
);
   initial o_reg = '0;

   // Released address and data lines show the inverse of their last value, so a stale copy never passes
   task automatic release_bus();
      o_reg.wr = 1'b0;
      o_reg.rd = 1'b0;
      o_reg.addr = ~o_reg.addr;
      o_reg.wdata = ~o_reg.wdata;
   endtask : release_bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge i_clk);
      o_reg.wr = 1'b1;
      o_reg.addr = a;
      o_reg.wdata = d;
      @(negedge i_clk);
      release_bus();
   endtask : wr

   // Answer stands one cycle only, so it is taken at the next falling edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge i_clk);
      o_reg.rd = 1'b1;
      o_reg.addr = a;
      @(negedge i_clk);
      d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 32'hxxxxxxxx;
      release_bus();
   endtask : rd
endmodule : mcz_host_model

// [bench/mcz_channel_path_tb_top.sv]
`timescale 1ns/1ps
module mcz_channel_path_tb_top
   import mcz_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_sys_rst;
   logic adc_valid;
   logic [2:0][23:0] adc_volt;
   logic [3:0][23:0] adc_curr;
   mcz_reg_req_t reg_req;
   logic [31:0] reg_rdata;
   logic reg_rvalid;
   logic path_valid;
   logic [2:0][23:0] path_volt;
   logic [2:0][23:0] path_curr;
   logic [2:0][23:0] path_power;
   logic smp_irq_n;
   logic evt_irq_n;
   int bad_count = 0;
   int n_compared = 0;

   // Short tick keeps the crossing scenario a few thousand cycles long
   mcz_channel_path #(.TICK_CYC(4)) i_mcz_channel_path (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_adc_valid(adc_valid),
      .i_adc_volt(adc_volt), .i_adc_curr(adc_curr), .i_reg(reg_req),
      .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .o_path_valid(path_valid),
      .o_path_volt(path_volt), .o_path_curr(path_curr), .o_path_power(path_power),
      .o_sample_interrupt_n(smp_irq_n), .o_event_interrupt_n(evt_irq_n));

   mcz_host_model i_mcz_host_model (
      .i_clk(i_clk), .o_reg(reg_req), .i_reg_rdata(reg_rdata), .i_reg_rvalid(reg_rvalid));

   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic end_sim();
      if (bad_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_mcz_host_model.wr(a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      i_mcz_host_model.rd(a, d);
      chk(d, exp);
   endtask : rdc

   function automatic logic [23:0] pw(input logic [23:0] v, input logic [23:0] c);
      logic signed [47:0] p;
      p = $signed(v) * $signed(c);
      return p[46:23];
   endfunction : pw

   // Path outputs settle three edges after the frame edge
   task automatic frame(input logic [71:0] v, input logic [95:0] c);
      @(negedge i_clk);
      adc_volt = v;
      adc_curr = c;
      adc_valid = 1'b1;
      @(negedge i_clk);
      adc_valid = 1'b0;
      repeat (2) @(negedge i_clk);
      chk(path_valid, 1'b1);
      @(negedge i_clk);
      chk(path_valid, 1'b0);
   endtask : frame

   task automatic t_reset();
      rdc(ADDR_CONFIG, 32'h0);
      rdc(ADDR_COEF, 32'h0);
      rdc(ADDR_BYPASS, 32'h0);
      rdc(ADDR_SECOND_STATUS_WORD, 32'h0);
      chk({30'h0, smp_irq_n, evt_irq_n}, 32'h3);
      rdc(8'hff, 32'h0);
      wr(ADDR_SAMPLE_A, 32'h00123456);
      rdc(ADDR_SAMPLE_A, 32'h0);
   endtask : t_reset

   task automatic t_hpf();
      frame({48'h0, 24'h100000}, 96'h0);
      frame({48'h0, 24'h100000}, 96'h0);
      chk(path_volt[0], 24'h0ffc00);
      rdc(ADDR_SAMPLE_A, 32'h000ffc00);
      wr(ADDR_BYPASS, 32'h00000100);
      frame({48'h0, 24'h100000}, 96'h0);
      chk(path_volt[0], 24'h100000);
   endtask : t_hpf

   task automatic t_gain();
      wr(ADDR_GAIN_A, 32'h00400000);
      rdc(ADDR_GAIN_A, 32'h00400000);
      wr(8'h03, 32'h00c00000);
      rdc(8'h03, 32'h0fc00000);
      wr(ADDR_COEF, 32'h0fff8000);
      rdc(ADDR_COEF, 32'h0fff8000);
      frame({FS_NEG, 24'h100000, 24'h100000}, {4{24'h200000}});
      chk(path_volt[0], 24'h180000);
      chk(path_volt[1], 24'h080000);
      chk(path_power[0], 24'h060000);
      chk(path_curr[0], 24'h200000);
      rdc(ADDR_SAMPLE_A, 32'h00180000);
      rdc(8'h07, 32'h00080000);
      rdc(8'h08, {8'hff, FS_NEG});
      wr(ADDR_GAIN_A, 32'h0);
      wr(8'h03, 32'h0);
   endtask : t_gain

   task automatic t_integ();
      wr(ADDR_CONFIG, 32'h00000001);
      frame(72'h0, {4{24'h100000}});
      chk(path_curr[0], 24'h001000);
      frame(72'h0, {4{24'h100000}});
      chk(path_curr[0], 24'h001ff0);
      wr(ADDR_CONFIG, 32'h0);
   endtask : t_integ

   task automatic t_route();
      logic [15:0] cfg [8];
      logic [5:0] src [8];
      logic [2:0][23:0] v;
      logic [2:0][23:0] c;
      logic [23:0] e;
      // Source phase per destination, C B A from the left; 3 means no source
      cfg = '{16'h1500, 16'h3f00, 16'h0200, 16'h0800, 16'h2000, 16'h0100, 16'h0400, 16'h1000};
      src = '{6'h12, 6'h24, 6'h07, 6'h2c, 6'h34, 6'h23, 6'h1c, 6'h34};
      v = {24'h30000c, 24'h200008, 24'h100004};
      c = {24'h100000, 24'h400000, 24'h200000};
      for (int k = 0; k < 8; k++)
      begin
         wr(ADDR_CONFIG, {16'h0, cfg[k]});
         frame(v, {24'h0, c});
         for (int d = 0; d < 3; d++)
         begin
            e = (src[k][2*d+:2] == 2'd3) ? 24'h0 : v[src[k][2*d+:2]];
            chk(path_volt[d], e);
            chk(path_power[d], pw(e, c[d]));
         end
      end
   endtask : t_route

   task automatic t_ready();
      wr(ADDR_FIRST_MASK_WORD, 32'h00020000);
      wr(ADDR_FIRST_STATUS_WORD, 32'h00020000);
      @(negedge i_clk);
      chk(smp_irq_n, 1'b1);
      frame(72'h0, 96'h0);
      @(negedge i_clk);
      chk(smp_irq_n, 1'b0);
      rdc(ADDR_FIRST_STATUS_WORD, 32'h00020000);
   endtask : t_ready

   task automatic t_cross();
      @(negedge i_clk);
      i_sys_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      i_sys_rst = 1'b0;
      wr(ADDR_BYPASS, 32'h00000001);
      wr(ADDR_SECOND_MASK_WORD, 32'h00002000);
      // Phase A large, phase B below the voltage threshold, phase C steady, neutral swings
      for (int k = 0; k < 800; k++)
      begin
         if (k == 405)
            rdc(ADDR_SECOND_STATUS_WORD, 32'h0);
         if (k < 400)
            frame({24'h300000, 24'h010000, 24'h400000},
                  {24'h400000, 24'h300000, 24'h010000, 24'h400000});
         else
            frame({24'h300000, 24'hff0000, 24'hc00000},
                  {24'hc00000, 24'h300000, 24'hff0000, 24'hc00000});
      end
      rdc(ADDR_SECOND_STATUS_WORD, 32'h00003200);
      chk(evt_irq_n, 1'b0);
      wr(ADDR_SECOND_STATUS_WORD, 32'h00002000);
      @(negedge i_clk);
      chk(evt_irq_n, 1'b1);
      rdc(ADDR_SECOND_STATUS_WORD, 32'h00001200);
   endtask : t_cross

   initial
   begin
      i_sys_rst = 1'b1;
      adc_valid = 1'b0;
      adc_volt = '0;
      adc_curr = '0;
      repeat (2) @(negedge i_clk);
      i_sys_rst = 1'b0;
      t_reset();
      t_hpf();
      t_gain();
      t_integ();
      t_route();
      t_ready();
      t_cross();
      end_sim();
   end

   // The whole sequence needs well under ten thousand cycles
   initial
   begin
      repeat (30000) @(posedge i_clk);
      bad_count++;
      end_sim();
   end
endmodule : mcz_channel_path_tb_top
